// *** common/pllc_pkg.sv ***
// Constants shared by the PLL loop and calibration control block
package pllc_pkg;
  // ==========================================================================
  // Register bus geometry and offsets
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 8;
  localparam logic [7:0]  OFF_LFO   = 8'h76;  // loop_filter_order_ctrl
  localparam logic [7:0]  OFF_CAL   = 8'h77;  // calibration_wait_ctrl
  localparam logic [7:0]  OFF_BW    = 8'h78;  // loop_bandwidth_ctrl

  // ==========================================================================
  // Field positions
  localparam int          LFO_LSB   = 0;
  localparam int          LFO_W     = 3;
  localparam int          CLSD_LSB  = 2;
  localparam int          VCO_LSB   = 0;
  localparam int          WAIT_W    = 2;
  localparam int          BW_BIT    = 0;

  // ==========================================================================
  // Values after reset and filter order codes
  localparam logic [2:0]  LFO_RST    = 3'h3;
  localparam logic [1:0]  CLSD_RST   = 2'h0;
  localparam logic [1:0]  VCO_RST    = 2'h1;
  localparam logic        BW_RST     = 1'b0;
  localparam logic [2:0]  LFO_SECOND = 3'h3;
  localparam logic [2:0]  LFO_THIRD  = 3'h7;

  // ==========================================================================
  // Wait periods in microseconds and their cycle counts at the core clock
  localparam int unsigned CLK_MHZ   = 50;
  localparam int unsigned CLSD_US0  = 30;
  localparam int unsigned CLSD_US1  = 300;
  localparam int unsigned CLSD_US2  = 30000;
  localparam int unsigned CLSD_US3  = 300000;
  localparam int unsigned VCO_US0   = 20;
  localparam int unsigned VCO_US1   = 400;
  localparam int unsigned VCO_US2   = 8000;
  localparam int unsigned VCO_US3   = 200000;
  localparam int unsigned CLSD_CYC0 = CLSD_US0 * CLK_MHZ;
  localparam int unsigned CLSD_CYC1 = CLSD_US1 * CLK_MHZ;
  localparam int unsigned CLSD_CYC2 = CLSD_US2 * CLK_MHZ;
  localparam int unsigned CLSD_CYC3 = CLSD_US3 * CLK_MHZ;
  localparam int unsigned VCO_CYC0  = VCO_US0 * CLK_MHZ;
  localparam int unsigned VCO_CYC1  = VCO_US1 * CLK_MHZ;
  localparam int unsigned VCO_CYC2  = VCO_US2 * CLK_MHZ;
  localparam int unsigned VCO_CYC3  = VCO_US3 * CLK_MHZ;
  localparam int          CNT_W_DEF = 24;

  // ==========================================================================
  // Calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_VCO  = 3'b010,
    CAL_CLSD = 3'b100
  } pllc_cal_t;
endpackage

// *** core/pllc_wait_timer.sv ***
// Down counter that times one calibration wait period
`timescale 1ns/100ps
module pllc_wait_timer #(
  parameter int CNT_W = 24
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_count,
  output logic                  o_done
);
  // ==========================================================================
  // Elaboration check
  if (CNT_W < 2) begin : g_chk
    $error("pllc_wait_timer: CNT_W must be at least 2");
  end

  logic [CNT_W-1:0] cnt_reg;

  // ==========================================================================
  // Counter; a load restarts it even mid-count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Done one cycle wide, i_count cycles after the load edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= !i_load && (cnt_reg == CNT_W'(1));
    end
  end
endmodule

// *** core/pllc_ctrl.sv ***
// PLL loop filter, bandwidth and calibration wait control registers
`timescale 1ns/100ps
module pllc_ctrl
  import pllc_pkg::*;
#(
  parameter int unsigned CLSD_CYC_0 = pllc_pkg::CLSD_CYC0,
  parameter int unsigned CLSD_CYC_1 = pllc_pkg::CLSD_CYC1,
  parameter int unsigned CLSD_CYC_2 = pllc_pkg::CLSD_CYC2,
  parameter int unsigned CLSD_CYC_3 = pllc_pkg::CLSD_CYC3,
  parameter int unsigned VCO_CYC_0  = pllc_pkg::VCO_CYC0,
  parameter int unsigned VCO_CYC_1  = pllc_pkg::VCO_CYC1,
  parameter int unsigned VCO_CYC_2  = pllc_pkg::VCO_CYC2,
  parameter int unsigned VCO_CYC_3  = pllc_pkg::VCO_CYC3,
  parameter int          CNT_W      = pllc_pkg::CNT_W_DEF
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic [pllc_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [pllc_pkg::DATA_W-1:0] i_reg_wdata,
  output logic      [pllc_pkg::DATA_W-1:0] o_reg_rdata,
  output logic                             o_reg_rvalid,
  input  wire logic                        i_cal_start,
  output logic                             o_cal_busy,
  output logic                             o_cal_done,
  output logic      [2:0]                  o_loop_filter_order_sel,
  output logic                             o_second_order,
  output logic                             o_third_order,
  output logic                             o_filter_reserved,
  output logic      [1:0]                  o_closed_loop_wait_sel,
  output logic      [1:0]                  o_vco_settle_wait_sel,
  output logic                             o_narrow_loop_bw_en
);
  import pllc_pkg::*;

  // ==========================================================================
  // Elaboration checks
  localparam longint unsigned MAX_CNT = (64'd1 << CNT_W) - 64'd1;
  if (CNT_W < 2 || CNT_W > 32) begin : g_chk_w
    $error("pllc_ctrl: CNT_W must lie in 2..32");
  end
  if (CLSD_CYC_0 < 1 || CLSD_CYC_1 < 1 || CLSD_CYC_2 < 1 || CLSD_CYC_3 < 1 ||
      VCO_CYC_0 < 1 || VCO_CYC_1 < 1 || VCO_CYC_2 < 1 || VCO_CYC_3 < 1) begin : g_chk_min
    $error("pllc_ctrl: every wait count must be at least 1");
  end
  if (CLSD_CYC_3 > MAX_CNT || VCO_CYC_3 > MAX_CNT ||
      CLSD_CYC_2 > MAX_CNT || VCO_CYC_2 > MAX_CNT) begin : g_chk_max
    $error("pllc_ctrl: wait count does not fit CNT_W");
  end

  // Maps a two-bit wait code onto its cycle count
  function automatic logic [CNT_W-1:0] pick_wait(input logic [1:0]  code,
                                                 input int unsigned c0,
                                                 input int unsigned c1,
                                                 input int unsigned c2,
                                                 input int unsigned c3);
    case (code)
      2'h0:    pick_wait = CNT_W'(c0);
      2'h1:    pick_wait = CNT_W'(c1);
      2'h2:    pick_wait = CNT_W'(c2);
      default: pick_wait = CNT_W'(c3);
    endcase
  endfunction

  logic [2:0]       lfo_reg;
  logic [1:0]       clsd_reg;
  logic [1:0]       vco_reg;
  logic             bw_reg;
  pllc_cal_t        cal_reg;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_done;
  logic             wr_lfo;
  logic             wr_cal;
  logic             wr_bw;

  // ==========================================================================
  // Register writes
  assign wr_lfo = i_reg_wr && (i_reg_addr == OFF_LFO);
  assign wr_cal = i_reg_wr && (i_reg_addr == OFF_CAL);
  assign wr_bw  = i_reg_wr && (i_reg_addr == OFF_BW);

  // Filter order store
  // Reserved codes are stored as written so software reads back its mistake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lfo_reg <= LFO_RST;
    end else if (wr_lfo) begin
      lfo_reg <= i_reg_wdata[LFO_LSB +: LFO_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clsd_reg <= CLSD_RST;
      vco_reg  <= VCO_RST;
    end else if (wr_cal) begin
      clsd_reg <= i_reg_wdata[CLSD_LSB +: WAIT_W];
      vco_reg  <= i_reg_wdata[VCO_LSB +: WAIT_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bw_reg <= BW_RST;
    end else if (wr_bw) begin
      bw_reg <= i_reg_wdata[BW_BIT];
    end
  end

  // ==========================================================================
  // Register reads, answered one cycle after the strobe
  // Reserved bits zero; unmapped offsets read all zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata  <= '0;
      if (i_reg_rd) begin
        case (i_reg_addr)
          OFF_LFO: o_reg_rdata <= {5'h00, lfo_reg};
          OFF_CAL: o_reg_rdata <= {4'h0, clsd_reg, vco_reg};
          OFF_BW:  o_reg_rdata <= {7'h00, bw_reg};
          default: o_reg_rdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Analog controls
  assign o_loop_filter_order_sel = lfo_reg;
  assign o_second_order          = (lfo_reg == LFO_SECOND);
  assign o_third_order           = (lfo_reg == LFO_THIRD);
  assign o_filter_reserved       = !o_second_order && !o_third_order;
  assign o_closed_loop_wait_sel  = clsd_reg;
  assign o_vco_settle_wait_sel   = vco_reg;
  assign o_narrow_loop_bw_en     = bw_reg;

  // ==========================================================================
  // Calibration sequencer: VCO settle wait, then closed-loop settle wait
  // Codes are sampled when each wait starts; a closed-loop code written during the VCO wait applies to this run
  // Wait period selection
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = pick_wait(vco_reg, VCO_CYC_0, VCO_CYC_1, VCO_CYC_2, VCO_CYC_3);
    case (cal_reg)
      CAL_IDLE: begin
        tmr_load = i_cal_start;
      end
      CAL_VCO: begin
        tmr_load  = tmr_done;
        tmr_count = pick_wait(clsd_reg, CLSD_CYC_0, CLSD_CYC_1, CLSD_CYC_2, CLSD_CYC_3);
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // Start pulses during a run are ignored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cal_reg    <= CAL_IDLE;
      o_cal_done <= 1'b0;
    end else begin
      o_cal_done <= 1'b0;
      case (cal_reg)
        CAL_IDLE: if (i_cal_start) begin
          cal_reg <= CAL_VCO;
        end
        CAL_VCO: if (tmr_done) begin
          cal_reg <= CAL_CLSD;
        end
        CAL_CLSD: if (tmr_done) begin
          cal_reg    <= CAL_IDLE;
          o_cal_done <= 1'b1;
        end
        default: cal_reg <= CAL_IDLE;
      endcase
    end
  end

  assign o_cal_busy = (cal_reg != CAL_IDLE);

  pllc_wait_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  // ==========================================================================
  // Checks; helper counts cycles since the timer was loaded
  logic [CNT_W-1:0] elapsed_reg;
  logic [CNT_W-1:0] expect_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      elapsed_reg <= '0;
      expect_reg  <= '0;
    end else if (tmr_load) begin
      elapsed_reg <= '0;
      expect_reg  <= tmr_count;
    end else if (o_cal_busy) begin
      elapsed_reg <= elapsed_reg + CNT_W'(1);
    end
  end

  reset_vals_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> lfo_reg == LFO_RST && clsd_reg == CLSD_RST && vco_reg == VCO_RST
                     && !o_narrow_loop_bw_en)
    else $error("register reset value wrong");
  second_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_lfo && i_reg_wdata[2:0] == 3'h3 |=> o_second_order && !o_third_order)
    else $error("code 3 did not select second order");
  third_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_lfo && i_reg_wdata[2:0] == 3'h7 |=> o_third_order && !o_second_order)
    else $error("code 7 did not select third order");
  filter_rsvd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_lfo && i_reg_wdata[1:0] != 2'h3 |=> o_filter_reserved)
    else $error("reserved filter code not flagged");
  rsvd_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == OFF_LFO |=> o_reg_rvalid && o_reg_rdata[7:3] == 5'h00
                                          && o_reg_rdata[2:0] == $past(lfo_reg))
    else $error("reserved bits not zero on read");
  narrow_bw_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_bw && i_reg_wdata[0] |=> o_narrow_loop_bw_en)
    else $error("narrow bandwidth not entered");
  // A write in the following cycle may legally set the bit again
  normal_bw_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_bw && !i_reg_wdata[0] ##1 !wr_bw |-> !o_narrow_loop_bw_en [*2])
    else $error("normal bandwidth not kept");
  vco_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cal_reg == CAL_VCO && tmr_done |-> elapsed_reg == expect_reg)
    else $error("VCO wait length wrong");
  clsd_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cal_reg == CAL_CLSD && tmr_done |=> o_cal_done && !o_cal_busy
                                        && $past(elapsed_reg) == $past(expect_reg))
    else $error("closed-loop wait length wrong");

  cal_run_c: cover property (@(posedge i_clk) disable iff (i_rst) o_cal_done);
  third_sel_c: cover property (@(posedge i_clk) disable iff (i_rst) o_third_order);
  narrow_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_narrow_loop_bw_en));
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the PLL loop and calibration control block
`timescale 1ns/100ps
module testbench;
  import pllc_pkg::*;
  // Shortened wait counts keep each calibration run to a few cycles
  localparam int VCY [4] = '{2, 3, 4, 5};
  localparam int CCY [4] = '{3, 4, 5, 6};

  logic        i_clk;
  logic        i_rst;
  logic [7:0]  i_reg_addr;
  logic        i_reg_wr;
  logic        i_reg_rd;
  logic [7:0]  i_reg_wdata;
  logic        i_cal_start;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        busy;
  logic        done;
  logic [2:0]  lfo;
  logic        second;
  logic        third;
  logic        resv;
  logic [1:0]  clsd;
  logic [1:0]  vco;
  logic        narrow;
  logic [2:0]  m_lfo;
  logic [3:0]  m_cal;
  logic        m_bw;
  logic [31:0] seed;
  int          errors;
  int          checks_done;

  pllc_ctrl #(
    .CLSD_CYC_0 (CCY[0]), .CLSD_CYC_1 (CCY[1]), .CLSD_CYC_2 (CCY[2]), .CLSD_CYC_3 (CCY[3]),
    .VCO_CYC_0  (VCY[0]), .VCO_CYC_1  (VCY[1]), .VCO_CYC_2  (VCY[2]), .VCO_CYC_3  (VCY[3])
  ) pllc_ctrl_i (
    .i_clk                   (i_clk),
    .i_rst                   (i_rst),
    .i_reg_addr              (i_reg_addr),
    .i_reg_wr                (i_reg_wr),
    .i_reg_rd                (i_reg_rd),
    .i_reg_wdata             (i_reg_wdata),
    .o_reg_rdata             (rdata),
    .o_reg_rvalid            (rvalid),
    .i_cal_start             (i_cal_start),
    .o_cal_busy              (busy),
    .o_cal_done              (done),
    .o_loop_filter_order_sel (lfo),
    .o_second_order          (second),
    .o_third_order           (third),
    .o_filter_reserved       (resv),
    .o_closed_loop_wait_sel  (clsd),
    .o_vco_settle_wait_sel   (vco),
    .o_narrow_loop_bw_en     (narrow)
  );

  // ==========================================================================
  // Clock, 20 ns period
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Expectation helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  // Unmapped offsets read as zero, upper bits always zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      OFF_LFO: return {5'h00, m_lfo};
      OFF_CAL: return {4'h0, m_cal};
      OFF_BW:  return {7'h00, m_bw};
      default: return 8'h00;
    endcase
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_c(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Static outputs against the bench's register image
  task automatic chk_outs();
    chk_v({5'h00, lfo}, {5'h00, m_lfo});
    chk_v({5'h00, resv, third, second}, {5'h00, !(m_lfo inside {3'h3, 3'h7}),
          m_lfo == 3'h7, m_lfo == 3'h3});
    chk_v({4'h0, clsd, vco}, {4'h0, m_cal});
    chk_v({7'h00, narrow}, {7'h00, m_bw});
  endtask

  // ==========================================================================
  // Bus and calibration drivers, all changes at the falling edge
  task automatic do_reset();
    i_rst = 1'b1;
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
    m_lfo = 3'h3;
    m_cal = 4'h1;
    m_bw  = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr    = 1'b1;
    i_reg_addr  = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    if (a == OFF_LFO) m_lfo = d[2:0];
    if (a == OFF_CAL) m_cal = d[3:0];
    if (a == OFF_BW) m_bw = d[0];
    chk_outs();
  endtask

  task automatic rd(input logic [7:0] a);
    i_reg_rd   = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk_v({7'h00, rvalid}, 8'h01);
    chk_v(rdata, exp_rd(a));
  endtask

  // Start, a refused restart while busy, then done V + C + 3 cycles on:
  // one cycle hands over between the waits, one registers the done pulse
  task automatic cal(input logic [1:0] v, input logic [1:0] c);
    int n;
    seed = lfsr_next(seed);
    wr(OFF_CAL, {seed[7:4], c, v});
    i_cal_start = 1'b1;
    @(negedge i_clk);
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      chk_v({7'h00, busy}, 8'h01);
      i_cal_start = (n == 2);
      @(negedge i_clk);
      n++;
    end
    i_cal_start = 1'b0;
    if (n >= 100) begin
      errors++;
      close_out();
    end else begin
      chk_c(n, VCY[v] + CCY[c] + 3);
      chk_v({7'h00, busy}, 8'h00);
      repeat (12) begin
        @(negedge i_clk);
        chk_v({7'h00, done}, 8'h00);
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] a;
    errors = 0;
    checks_done = 0;
    seed = 32'h3e2aea37;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_cal_start = 1'b0;
    do_reset();
    chk_outs();
    // Reads one cycle apart so the strobe drops between them
    for (int k = 0; k < 3; k++) begin
      rd(OFF_LFO + 8'(k));
      @(negedge i_clk);
      chk_v(rdata | {7'h00, rvalid}, 8'h00);
    end
    $display("test reset values done");
    // Every filter order code, with junk in the reserved bits
    for (int k = 0; k < 8; k++) begin
      seed = lfsr_next(seed);
      wr(OFF_LFO, {seed[7:3], 3'(k)});
      rd(OFF_LFO);
    end
    $display("test filter codes done");
    repeat (40) begin
      seed = lfsr_next(seed);
      a = OFF_LFO + 8'(seed[9:8] % 3);
      wr(a, seed[7:0]);
      rd(a);
    end
    $display("test random access done");
    repeat (8) begin
      seed = lfsr_next(seed);
      a = (seed[7:0] inside {OFF_LFO, OFF_CAL, OFF_BW}) ? seed[7:0] ^ 8'h80 : seed[7:0];
      wr(a, seed[15:8]);
      rd(a);
      @(negedge i_clk);
      chk_v(rdata | {7'h00, rvalid}, 8'h00);
    end
    $display("test unmapped offsets done");
    for (int v = 0; v < 4; v++) begin
      for (int c = 0; c < 4; c++) begin
        cal(2'(v), 2'(c));
      end
    end
    $display("test calibration waits done");
    // Narrow bandwidth with a matching filter order, then the usual VCO code
    wr(OFF_BW, 8'h01);
    rd(OFF_BW);
    wr(OFF_LFO, 8'h07);
    rd(OFF_LFO);
    cal(2'h1, 2'h1);
    $display("test bandwidth change done");
    do_reset();
    chk_outs();
    rd(OFF_CAL);
    $display("test second reset done");
    close_out();
  end
endmodule
